/* spd_dev_ctl_status.sv */
// Device control and status register pair of one switch port, reached over AXI4-Lite.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

// What this block does
// - Bit 0 correctable reporting enable, resets zero.
// - Bit 1 non-fatal reporting enable, resets zero.
// - Bit 2 fatal reporting enable, resets zero.
// - Bit 3 unsupported request reporting enable.
// - Bit 4 relaxed ordering reads zero.
// - Bits 7:5 payload size, clamped on write.
// - Bits 8, 9 always read zero.
// - Bit 10 auxiliary power enable, read-write.
// - Bit 11 no-snoop reads zero.
// - Bits 14:12 read request size fixed zero.
// - Status 16 correctable detected, write-one-clear.
// - Status 17 non-fatal detected, write-one-clear.
// - Status 18 fatal detected, write-one-clear.
// - Status 19 unsupported detected, write-one-clear.
// - Flags log errors regardless of enables.
// - Status 20 aux power present, resets one.
// - Status 21 transactions pending reads zero.
// - Reserved bits read zero, writes ignored.
// - Codes 128, 256, 512 bytes; others reserved.
// - Supported maximum follows the payload strap.
module spd_dev_ctl_status
  import spd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire spd_axil_req_t axiReq,
  output spd_axil_rsp_t axiRsp,
  input wire spd_err_t errDetected,
  input wire logic auxPowerSense,
  input wire logic payload_large_strap,
  output spd_err_t errReport,
  output logic [2:0] maxPayloadCode,
  output logic auxPowerPmEnable
);

  // Clamp a requested payload code to the supported maximum.
  function automatic logic [2:0] clampPayload(input logic [2:0] code, input logic [2:0] limit);
    if (code > limit)
    begin
      return limit;
    end
    return code;
  endfunction

  // Register-word address decode, shared by the read and write paths.
  function automatic logic hitsCtlStatus(input logic [7:0] addr);
    return addr[7:SPD_ADDR_LSB] == SPD_ADDR_CTL_STATUS[7:SPD_ADDR_LSB];
  endfunction

  logic [3:0] errEnable;
  logic [2:0] payloadCode;
  logic auxPmEn;
  logic [3:0] errFlags;
  logic auxDetected;
  logic strapLarge;

  logic awHeld;
  logic wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;

  // Response flops; the bus struct is only wiring, so each field keeps a single driver.
  logic awReady;
  logic wReady;
  logic bValid;
  logic [1:0] bResp;
  logic arReady;
  logic rValid;
  logic [31:0] rData;
  logic [1:0] rResp;

  assign axiRsp = '{awready: awReady, wready: wReady, bresp: bResp, bvalid: bValid,
    arready: arReady, rdata: rData, rresp: rResp, rvalid: rValid};

  wire awTaken = axiReq.awvalid && awReady;
  wire wTaken = axiReq.wvalid && wReady;
  wire bDone = bValid && axiReq.bready;
  wire arTaken = axiReq.arvalid && arReady;
  wire rDone = rValid && axiReq.rready;

  // The write commits one edge after both halves are held, so each half may arrive first.
  wire writeFire = awHeld && wHeld && !bValid;
  wire writeHit = writeFire && hitsCtlStatus(awAddr);

  // Supported maximum is taken from the strap while reset is held, then frozen.
  wire [2:0] supportedMax = strapLarge ? SPD_MPS_512 : SPD_MPS_256;

  wire ctlLoLane = writeHit && wStrb[SPD_LANE_CTL_LO];
  wire ctlHiLane = writeHit && wStrb[SPD_LANE_CTL_HI];
  wire stsLoLane = writeHit && wStrb[SPD_LANE_STS_LO];

  wire [3:0] next_errEnable = ctlLoLane ?
    wData[SPD_CTL_UNSUP_EN:SPD_CTL_CORR_EN] : errEnable;
  wire [2:0] next_payloadCode = ctlLoLane ?
    clampPayload(wData[SPD_CTL_MPS_HI:SPD_CTL_MPS_LO], supportedMax) : payloadCode;
  wire next_auxPmEn = ctlHiLane ? wData[SPD_CTL_AUX_PM_EN] : auxPmEn;

  // A new detection in the same cycle as a write-one-clear keeps the flag set.
  wire [3:0] clearMask = stsLoLane ? wData[SPD_STS_ERR_HI:SPD_STS_ERR_LO] : 4'h0;
  logic [3:0] next_errFlags;
  for (genvar i = 0; i < 4; i++)
  begin : g_flag
    assign next_errFlags[i] = (errFlags[i] && !clearMask[i]) || errDetected[i];
  end

  // Only enabled classes leave the port; logging above ignores the enables.
  wire [3:0] next_errReport = errDetected & errEnable;

  // Every bit not named below stays zero on read, including the reserved ones.
  logic [31:0] regWord;
  always_comb
  begin
    regWord = 32'h0;
    regWord[SPD_CTL_UNSUP_EN:SPD_CTL_CORR_EN] = errEnable;
    regWord[SPD_CTL_RELAXED] = 1'b0;
    regWord[SPD_CTL_MPS_HI:SPD_CTL_MPS_LO] = payloadCode;
    regWord[SPD_CTL_EXT_TAG] = 1'b0;
    regWord[SPD_CTL_PHANTOM] = 1'b0;
    regWord[SPD_CTL_AUX_PM_EN] = auxPmEn;
    regWord[SPD_CTL_NO_SNOOP] = 1'b0;
    regWord[SPD_CTL_MRRS_HI:SPD_CTL_MRRS_LO] = SPD_MRRS_FIXED;
    regWord[SPD_STS_ERR_HI:SPD_STS_ERR_LO] = errFlags;
    regWord[SPD_STS_AUX_DET] = auxDetected;
    regWord[SPD_STS_PENDING] = 1'b0;
  end

  wire [31:0] next_rdata = hitsCtlStatus(axiReq.araddr) ? regWord : 32'h0;
  wire [1:0] next_rresp = hitsCtlStatus(axiReq.araddr) ? SPD_RESP_OKAY : SPD_RESP_SLVERR;
  wire [1:0] next_bresp = hitsCtlStatus(awAddr) ? SPD_RESP_OKAY : SPD_RESP_SLVERR;

  // Strap capture: sampled every cycle while reset is held, then kept.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      strapLarge <= payload_large_strap;
    end
  end

  // Each stored control and status field sits in a short register of its own; the fixed fields have none.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      errEnable <= SPD_RST_ERR_EN;
    end
    else
    begin
      errEnable <= next_errEnable;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      payloadCode <= SPD_RST_MPS;
    end
    else
    begin
      payloadCode <= next_payloadCode;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      auxPmEn <= SPD_RST_AUX_PM_EN;
    end
    else
    begin
      auxPmEn <= next_auxPmEn;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      errFlags <= SPD_RST_ERR_FLAGS;
    end
    else
    begin
      errFlags <= next_errFlags;
    end
  end

  // Presence is re-read every cycle, so a lost supply shows one cycle later.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      auxDetected <= SPD_RST_AUX_DET;
    end
    else
    begin
      auxDetected <= auxPowerSense;
    end
  end

  // Upstream report pulse, one cycle after the detection.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      errReport <= '0;
    end
    else
    begin
      errReport <= next_errReport;
    end
  end

  // Side outputs that steer the port's own datapath.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      maxPayloadCode <= SPD_RST_MPS;
      auxPowerPmEnable <= SPD_RST_AUX_PM_EN;
    end
    else
    begin
      maxPayloadCode <= next_payloadCode;
      auxPowerPmEnable <= next_auxPmEn;
    end
  end

  // Write address and data halves, each held until the response is taken.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      awHeld <= 1'b0;
      awAddr <= 8'h0;
    end
    else if (awTaken)
    begin
      awHeld <= 1'b1;
      awAddr <= axiReq.awaddr;
    end
    else if (bDone)
    begin
      awHeld <= 1'b0;
    end
  end

  // Ready stays low while a half is held, so a second write cannot overtake the first.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      awReady <= 1'b0;
    end
    else if (awTaken)
    begin
      awReady <= 1'b0;
    end
    else if (bDone || !awHeld)
    begin
      awReady <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wHeld <= 1'b0;
      wData <= 32'h0;
      wStrb <= 4'h0;
    end
    else if (wTaken)
    begin
      wHeld <= 1'b1;
      wData <= axiReq.wdata;
      wStrb <= axiReq.wstrb;
    end
    else if (bDone)
    begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wReady <= 1'b0;
    end
    else if (wTaken)
    begin
      wReady <= 1'b0;
    end
    else if (bDone || !wHeld)
    begin
      wReady <= 1'b1;
    end
  end

  // Write response.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bValid <= 1'b0;
      bResp <= SPD_RESP_OKAY;
    end
    else if (writeFire)
    begin
      bValid <= 1'b1;
      bResp <= next_bresp;
    end
    else if (bDone)
    begin
      bValid <= 1'b0;
    end
  end

  // Read channel: one read in flight, data captured at the address handshake.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      arReady <= 1'b0;
    end
    else if (arTaken)
    begin
      arReady <= 1'b0;
    end
    else if (rDone || !rValid)
    begin
      arReady <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rValid <= 1'b0;
    end
    else if (arTaken)
    begin
      rValid <= 1'b1;
    end
    else if (rDone)
    begin
      rValid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rData <= 32'h0;
      rResp <= SPD_RESP_OKAY;
    end
    else if (arTaken)
    begin
      rData <= next_rdata;
      rResp <= next_rresp;
    end
  end

endmodule

/* spd_dev_ctl_status_asserts.sv */
// Assertions on the port device control and status register pair.
`timescale 1ns/1ps
module spd_dev_ctl_status_asserts
  import spd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire spd_axil_req_t axiReq,
  input wire spd_axil_rsp_t axiRsp,
  input wire spd_err_t errDetected,
  input wire logic auxPowerSense,
  input wire logic payload_large_strap,
  input wire spd_err_t errReport,
  input wire logic [2:0] maxPayloadCode,
  input wire logic auxPowerPmEnable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire rdTaken = axiReq.arvalid && axiRsp.arready;
  wire wrTaken = axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
  property p_report;
    errReport != 4'h0 |-> (errReport & ~$past(errDetected)) == 4'h0;
  endproperty
  // Supported maximum as the design sees it: the strap level at the last reset edge.
  logic strapSeen;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      strapSeen <= payload_large_strap;
    end
  end
  property p_mps;
    maxPayloadCode <= (strapSeen ? SPD_MPS_512 : SPD_MPS_256);
  endproperty
  property p_rsvd;
    axiRsp.rvalid |-> axiRsp.rdata[31:22] == 10'h0 && !axiRsp.rdata[15];
  endproperty
  property p_ro;
    axiRsp.rvalid |-> {axiRsp.rdata[21], axiRsp.rdata[14:11], axiRsp.rdata[9:8],
      axiRsp.rdata[4]} == 8'h0;
  endproperty
  property p_rlat;
    rdTaken |=> axiRsp.rvalid && !axiRsp.arready;
  endproperty
  property p_wlat;
    wrTaken |=> !axiRsp.bvalid ##1 axiRsp.bvalid;
  endproperty
  property p_rresp;
    rdTaken |=> axiRsp.rresp == ($past(axiReq.araddr[7:2]) == 6'h32 ? SPD_RESP_OKAY
      : SPD_RESP_SLVERR);
  endproperty
  property p_rstval;
    $fell(rst) |-> errReport == 4'h0 && maxPayloadCode == 3'h0 && !auxPowerPmEnable;
  endproperty
  a_report: assert property (p_report) else $error("report without detection");
  a_mps: assert property (p_mps) else $error("payload code above limit");
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  a_ro: assert property (p_ro) else $error("fixed bits set");
  a_rlat: assert property (p_rlat) else $error("read answer late");
  a_wlat: assert property (p_wlat) else $error("write answer off");
  a_rresp: assert property (p_rresp) else $error("read response wrong");
  a_rstval: assert property (p_rstval) else $error("reset value wrong");
  c_rd: cover property (rdTaken);
  c_rep: cover property (errReport != 4'h0);
  c_err: cover property (axiRsp.bvalid && axiRsp.bresp == SPD_RESP_SLVERR);
endmodule
bind spd_dev_ctl_status spd_dev_ctl_status_asserts spd_asrt_i (.ref_clk(ref_clk), .rst(rst),
  .axiReq(axiReq), .axiRsp(axiRsp), .errDetected(errDetected), .auxPowerSense(auxPowerSense),
  .payload_large_strap(payload_large_strap), .errReport(errReport),
  .maxPayloadCode(maxPayloadCode), .auxPowerPmEnable(auxPowerPmEnable));

/* spd_pkg.sv */
// Constants and bus carriers for the port device control and status register pair.
package spd_pkg;

  localparam logic [7:0] SPD_ADDR_CTL_STATUS = 8'hc8;
  localparam int SPD_ADDR_LSB = 2;

  // Control word field positions, all inside the low half of the register word.
  localparam int SPD_CTL_CORR_EN = 0;
  localparam int SPD_CTL_NONFATAL_EN = 1;
  localparam int SPD_CTL_FATAL_EN = 2;
  localparam int SPD_CTL_UNSUP_EN = 3;
  localparam int SPD_CTL_RELAXED = 4;
  localparam int SPD_CTL_MPS_LO = 5;
  localparam int SPD_CTL_MPS_HI = 7;
  localparam int SPD_CTL_EXT_TAG = 8;
  localparam int SPD_CTL_PHANTOM = 9;
  localparam int SPD_CTL_AUX_PM_EN = 10;
  localparam int SPD_CTL_NO_SNOOP = 11;
  localparam int SPD_CTL_MRRS_LO = 12;
  localparam int SPD_CTL_MRRS_HI = 14;
  localparam int SPD_CTL_RSVD = 15;

  // Status word field positions, in the high half of the register word.
  localparam int SPD_STS_ERR_LO = 16;
  localparam int SPD_STS_ERR_HI = 19;
  localparam int SPD_STS_AUX_DET = 20;
  localparam int SPD_STS_PENDING = 21;
  localparam int SPD_STS_RSVD_LO = 22;
  localparam int SPD_STS_RSVD_HI = 31;

  // Byte lanes that carry each writable group.
  localparam int SPD_LANE_CTL_LO = 0;
  localparam int SPD_LANE_CTL_HI = 1;
  localparam int SPD_LANE_STS_LO = 2;

  // Payload size codes.
  localparam logic [2:0] SPD_MPS_128 = 3'h0;
  localparam logic [2:0] SPD_MPS_256 = 3'h1;
  localparam logic [2:0] SPD_MPS_512 = 3'h2;

  // Reset values.
  localparam logic [3:0] SPD_RST_ERR_EN = 4'h0;
  localparam logic [2:0] SPD_RST_MPS = 3'h0;
  localparam logic SPD_RST_AUX_PM_EN = 1'b0;
  localparam logic [3:0] SPD_RST_ERR_FLAGS = 4'h0;
  localparam logic SPD_RST_AUX_DET = 1'b1;
  localparam logic [2:0] SPD_MRRS_FIXED = 3'h0;

  // Bus responses.
  localparam logic [1:0] SPD_RESP_OKAY = 2'h0;
  localparam logic [1:0] SPD_RESP_SLVERR = 2'h2;

  // Error classes in the order of the enable and detected bits.
  typedef struct packed {
    logic unsupported;
    logic fatal;
    logic nonfatal;
    logic correctable;
  } spd_err_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic [2:0] awprot;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic [2:0] arprot;
    logic arvalid;
    logic rready;
  } spd_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } spd_axil_rsp_t;

endpackage

/* testbench.sv */
// Self-checking bench for the port device control and status register pair.
`timescale 1ns/1ps
module testbench
  import spd_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  spd_axil_req_t axiReq = '0;
  spd_axil_rsp_t axiRsp;
  spd_err_t errDetected = '0;
  logic auxPowerSense = 1'b1;
  logic largeStrap = 1'b0;
  spd_err_t errReport;
  logic [2:0] maxPayloadCode;
  logic auxPowerPmEnable;
  logic [31:0] rdData;
  logic [1:0] resp;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  spd_dev_ctl_status spd_dev_ctl_status_i (.ref_clk(ref_clk), .rst(rst), .axiReq(axiReq),
    .axiRsp(axiRsp), .errDetected(errDetected), .auxPowerSense(auxPowerSense),
    .payload_large_strap(largeStrap), .errReport(errReport),
    .maxPayloadCode(maxPayloadCode), .auxPowerPmEnable(auxPowerPmEnable));
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // The whole run needs well under a thousand cycles; a hang is cut at four thousand.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Each access starts one edge later, so a released strobe is never raised in the same step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge ref_clk);
    axiReq.awaddr <= a;
    axiReq.wdata <= d;
    axiReq.wstrb <= s;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
    end
    while (axiRsp.bvalid !== 1'b1);
    axiReq.bready <= 1'b0;
    resp = axiRsp.bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
    end
    while (axiRsp.rvalid !== 1'b1);
    axiReq.rready <= 1'b0;
    rdData = axiRsp.rdata;
    resp = axiRsp.rresp;
  endtask
  task automatic pulse(input spd_err_t e, input logic [3:0] exp);
    @(posedge ref_clk);
    errDetected <= e;
    @(posedge ref_clk);
    errDetected <= 4'h0;
    #1 chk(32'(errReport), 32'(exp));
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd(8'hc8);
    chk(rdData, 32'h0010_0000);
    $display("test reset values done");
    wr(8'hc8, 32'hffff_ffff, 4'hf);
    chk(32'(resp), 32'(SPD_RESP_OKAY));
    rd(8'hc8);
    chk(rdData, 32'h0010_042f);
    chk(32'(maxPayloadCode), 32'h1);
    chk(32'(auxPowerPmEnable), 32'h1);
    $display("test write all ones done");
    for (int c = 0; c < 8; c++)
    begin
      wr(8'hc8, 32'(c) << 5, 4'h1);
      rd(8'hc8);
      chk(rdData, 32'h0010_0400 | (32'(c > 1 ? 1 : c) << 5));
    end
    $display("test payload codes done");
    wr(8'hc8, 32'h0000_000f, 4'h1);
    pulse(4'h5, 4'h5);
    wr(8'hc8, 32'h0, 4'h3);
    pulse(4'ha, 4'h0);
    pulse(4'h5, 4'h0);
    rd(8'hc8);
    chk(rdData, 32'h001f_0000);
    chk(32'(auxPowerPmEnable), 32'h0);
    wr(8'hc8, 32'h0005_0000, 4'h4);
    wr(8'hc8, 32'hffff_0000, 4'h3);
    rd(8'hc8);
    chk(rdData, 32'h001a_0000);
    wr(8'hc8, 32'h000f_0000, 4'h4);
    rd(8'hc8);
    chk(rdData, 32'h0010_0000);
    $display("test error flags done");
    auxPowerSense <= 1'b0;
    rd(8'hc8);
    chk(rdData, 32'h0);
    auxPowerSense <= 1'b1;
    rd(8'hcc);
    chk(32'(resp), 32'(SPD_RESP_SLVERR));
    chk(rdData, 32'h0);
    wr(8'hcc, 32'hffff_ffff, 4'hf);
    chk(32'(resp), 32'(SPD_RESP_SLVERR));
    rd(8'hc8);
    chk(rdData, 32'h0010_0000);
    $display("test aux sense and unmapped done");
    largeStrap <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    wr(8'hc8, 32'h0000_00e0, 4'h1);
    rd(8'hc8);
    chk(rdData, 32'h0010_0040);
    chk(32'(maxPayloadCode), 32'(SPD_MPS_512));
    $display("test large strap done");
    stop_test();
  end
endmodule
